// [synth_control_pin_interface.sv]
`timescale 1ns/1ps
module synth_control_pin_interface
	import synth_pins_pkg::*;
#(
	parameter int NUM = NUM_REGS,
	parameter int W = REG_W,
	parameter int AW = ADDR_W
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// serial port pins
	input wire serial_in_t serial_i,
	input wire logic serial_port_abort_i,
	input wire logic three_wire_mode_i,
	output pin_drive_t serial_data_o,
	output pin_drive_t serial_out_pin_o,
	// update strobe and active registers
	input wire logic io_update_i,
	output logic [NUM-1:0][W-1:0] active_regs_o,
	// multi-device sync
	input wire logic sync_in_i,
	output logic sync_clk_o,
	// shaped keying
	input wire logic keying_enable_i,
	input wire logic keying_ramp_direction_i,
	output logic ramp_up_o,
	// clock and power control
	input wire logic oscillator_enable_pin_i,
	input wire logic external_powerdown_pin_i,
	input wire logic [4:0] refclk_mult_i,
	output logic osc_section_en_o,
	output logic ref_direct_o,
	output logic powerdown_o,
	output logic [4:0] pll_factor_o,
	output logic pll_bypass_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] sync_r;
	wire logic [SYNC_W-1:0] raw_pins = {serial_i.clk, serial_i.sel_n, serial_i.data,
		serial_port_abort_i, io_update_i, sync_in_i, keying_enable_i,
		keying_ramp_direction_i, oscillator_enable_pin_i, external_powerdown_pin_i,
		three_wire_mode_i, refclk_mult_i};

	// two flops on every pin; only the second stage is read
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			meta_r <= SYNC_RST;
			sync_r <= SYNC_RST;
		end else begin
			meta_r <= raw_pins;
			sync_r <= meta_r;
		end
	end

	// named views of the synchronised pins
	wire logic sclk_s = sync_r[15];
	wire logic sel_n_s = sync_r[14];
	wire logic data_s = sync_r[13];
	wire logic abort_s = sync_r[12];
	wire logic update_s = sync_r[11];
	wire logic sync_in_s = sync_r[10];
	wire logic key_en_s = sync_r[9];
	wire logic key_dir_s = sync_r[8];
	wire logic osc_en_s = sync_r[7];
	wire logic pd_s = sync_r[6];
	wire logic three_wire_s = sync_r[5];
	wire logic [4:0] mult_s = sync_r[4:0];

	// ----------------------------------------------------------------
	// edge detection on synchronised levels
	// ----------------------------------------------------------------
	logic sclk_prev_r;
	logic update_prev_r;
	logic sync_in_prev_r;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sclk_prev_r <= 1'b0;
			update_prev_r <= 1'b0;
			sync_in_prev_r <= 1'b0;
		end else begin
			sclk_prev_r <= sclk_s;
			update_prev_r <= update_s;
			sync_in_prev_r <= sync_in_s;
		end
	end

	// bit clock edges come from the host clock pin
	wire logic sclk_rise = sclk_s & ~sclk_prev_r;
	wire logic sclk_fall = ~sclk_s & sclk_prev_r;
	wire logic update_rise = update_s & ~update_prev_r;
	wire logic sync_in_rise = sync_in_s & ~sync_in_prev_r;

	// ----------------------------------------------------------------
	// serial port controller
	// ----------------------------------------------------------------
	port_state_t state_r;
	port_state_t state_nxt;
	logic [5:0] bit_cnt_r;
	logic [5:0] bit_cnt_nxt;
	logic [INSTR_W-1:0] instr_r;
	logic [INSTR_W-1:0] instr_nxt;
	logic [W-1:0] shift_r;
	logic [W-1:0] shift_nxt;
	logic [W-1:0] rd_shift_r;
	logic [W-1:0] rd_shift_nxt;
	logic out_bit_r;
	logic out_bit_nxt;
	logic wr_en_r;
	logic wr_en_nxt;
	logic [AW-1:0] wr_addr_r;
	logic [W-1:0] wr_data_r;
	logic data_oe_n_r;
	logic so_oe_n_r;

	logic [NUM-1:0][W-1:0] buffer_words;
	logic [NUM-1:0][W-1:0] active_r;

	// decode of the instruction as it completes
	wire logic [INSTR_W-1:0] instr_new = {instr_r[INSTR_W-2:0], data_s};
	wire logic [AW-1:0] instr_new_addr = instr_new[AW-1:0];
	wire logic reading = instr_r[INSTR_RW_BIT];
	wire logic [W-1:0] word_new = {shift_r[W-2:0], data_s};
	wire logic instr_last = bit_cnt_r == 6'(INSTR_W - 1);
	wire logic data_last = bit_cnt_r == 6'(W - 1);
	wire logic [W-1:0] rd_word = active_r[instr_new_addr];

	// a reader drives only during its data phase; pin choice by wiring mode
	wire logic drive_nxt = (state_nxt == ST_DATA) && instr_nxt[INSTR_RW_BIT];

	// next state of the shift engine
	always_comb begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		instr_nxt = instr_r;
		shift_nxt = shift_r;
		rd_shift_nxt = rd_shift_r;
		out_bit_nxt = out_bit_r;
		wr_en_nxt = 1'b0;
		if (abort_s || sel_n_s) begin
			// deselected or aborted: bit count starts over
			state_nxt = ST_IDLE;
			bit_cnt_nxt = BIT_CNT_ZERO;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					state_nxt = ST_INSTR;
					bit_cnt_nxt = BIT_CNT_ZERO;
				end
				ST_INSTR: begin
					if (sclk_rise) begin
						instr_nxt = instr_new;
						bit_cnt_nxt = bit_cnt_r + BIT_CNT_ONE;
						if (instr_last) begin
							state_nxt = ST_DATA;
							bit_cnt_nxt = BIT_CNT_ZERO;
							rd_shift_nxt = rd_word;
						end
					end
				end
				ST_DATA: begin
					if (sclk_fall && reading) begin
						// read bits change on the falling edge, msb first
						out_bit_nxt = rd_shift_r[W-1];
						rd_shift_nxt = {rd_shift_r[W-2:0], 1'b0};
					end
					if (sclk_rise) begin
						bit_cnt_nxt = bit_cnt_r + BIT_CNT_ONE;
						if (!reading) begin
							shift_nxt = word_new;
						end
						if (data_last) begin
							wr_en_nxt = !reading;
							state_nxt = ST_INSTR;
							bit_cnt_nxt = BIT_CNT_ZERO;
						end
					end
				end
				default: begin
					state_nxt = ST_IDLE;
					bit_cnt_nxt = BIT_CNT_ZERO;
				end
			endcase
		end
	end

	// abort clears the controller at once, without a clock
	always_ff @(posedge core_clk_i or posedge serial_port_abort_i) begin
		if (serial_port_abort_i) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= BIT_CNT_ZERO;
			instr_r <= '0;
			shift_r <= '0;
			rd_shift_r <= '0;
			out_bit_r <= 1'b0;
			wr_en_r <= 1'b0; // no partial word reaches the buffer
		end else if (reset_i) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= BIT_CNT_ZERO;
			instr_r <= '0;
			shift_r <= '0;
			rd_shift_r <= '0;
			out_bit_r <= 1'b0;
			wr_en_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			instr_r <= instr_nxt;
			shift_r <= shift_nxt;
			rd_shift_r <= rd_shift_nxt;
			out_bit_r <= out_bit_nxt;
			wr_en_r <= wr_en_nxt;
		end
	end

	// output enables, released at once by abort
	always_ff @(posedge core_clk_i or posedge serial_port_abort_i) begin
		if (serial_port_abort_i) begin
			data_oe_n_r <= 1'b1;
			so_oe_n_r <= 1'b1;
		end else if (reset_i) begin
			data_oe_n_r <= 1'b1;
			so_oe_n_r <= 1'b1;
		end else begin
			data_oe_n_r <= !(drive_nxt && !three_wire_s);
			so_oe_n_r <= !(drive_nxt && three_wire_s);
		end
	end

	// write word and address held beside the strobe
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wr_addr_r <= '0;
			wr_data_r <= '0;
		end else if (wr_en_nxt) begin
			wr_addr_r <= instr_r[AW-1:0];
			wr_data_r <= word_new;
		end
	end

	// ----------------------------------------------------------------
	// buffer and active registers
	// ----------------------------------------------------------------
	write_buffer #(
		.NUM(NUM),
		.W(W),
		.AW(AW)
	) u_buffer (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.wr_en_i(wr_en_r),
		.wr_addr_i(wr_addr_r),
		.wr_data_i(wr_data_r),
		.words_o(buffer_words)
	);

	// whole buffer lands in one cycle, so the device never sees half a set
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			active_r <= '0;
		end else if (update_rise) begin
			active_r <= buffer_words;
		end
	end

	// ----------------------------------------------------------------
	// sync clock divider and keying direction
	// ----------------------------------------------------------------
	logic [1:0] sync_cnt_r;
	logic sync_clk_r;
	logic ramp_up_r;

	// a peer's sync clock edge restarts our phase
	wire logic [1:0] sync_cnt_nxt = sync_in_rise ? SYNC_CNT_ONE : sync_cnt_r + SYNC_CNT_ONE;
	wire logic sync_tick = sync_cnt_nxt == SYNC_CNT_ZERO;

	// divider never stops, even under abort
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sync_cnt_r <= SYNC_CNT_HALF; // low half, matches the low output: no runt after reset
			sync_clk_r <= 1'b0;
		end else begin
			sync_cnt_r <= sync_cnt_nxt;
			sync_clk_r <= sync_cnt_nxt < SYNC_CNT_HALF;
		end
	end

	// sample keying once per sync period, when it is known to be still
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ramp_up_r <= 1'b0;
		end else if (!key_en_s) begin
			ramp_up_r <= 1'b0; // pin ignored while keying is off
		end else if (sync_tick) begin
			ramp_up_r <= key_dir_s;
		end
	end

	// ----------------------------------------------------------------
	// clock source and power control
	// ----------------------------------------------------------------
	logic osc_en_r;
	logic ref_direct_r;
	logic pd_r;
	logic [4:0] pll_factor_r;
	logic pll_bypass_r;

	// out-of-range factors fall back to the bare reference
	wire logic mult_in_range = (mult_s >= MULT_MIN) && (mult_s <= MULT_MAX);

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			osc_en_r <= 1'b0;
			ref_direct_r <= 1'b1;
			pd_r <= 1'b0;
			pll_factor_r <= MULT_UNITY;
			pll_bypass_r <= 1'b1;
		end else begin
			osc_en_r <= osc_en_s;
			ref_direct_r <= !osc_en_s;
			pd_r <= pd_s;
			pll_factor_r <= mult_in_range ? mult_s : MULT_UNITY;
			pll_bypass_r <= !mult_in_range;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flops
	// ----------------------------------------------------------------
	assign serial_data_o.data = out_bit_r;
	assign serial_data_o.oe_n = data_oe_n_r;
	assign serial_out_pin_o.data = out_bit_r;
	assign serial_out_pin_o.oe_n = so_oe_n_r;
	assign active_regs_o = active_r;
	assign sync_clk_o = sync_clk_r;
	assign ramp_up_o = ramp_up_r;
	assign osc_section_en_o = osc_en_r;
	assign ref_direct_o = ref_direct_r;
	assign powerdown_o = pd_r;
	assign pll_factor_o = pll_factor_r;
	assign pll_bypass_o = pll_bypass_r;

endmodule

// [synth_pins_pkg.sv]
// Contract
// - rising update strobe copies whole write buffer into active registers at once
// - active-high hardware reset returns all state to initial values
// - port abort resets serial controller asynchronously, active high
// - abort discards transfer in progress; host restarts only after abort low
// - three-wire mode: data pin input only, reads leave on serial out pin
// - two-wire mode: data pin carries both directions, serial out pin unused
// - serial transfers accepted only while active-low chip select is low
// - sync input from another device realigns own sync timing
// - free-running sync clock output as timing reference
// - with keying enabled, keying input level picks ramp up or ramp down
// - oscillator pin high enables oscillator section, low uses reference directly
// - dedicated external power-down input places device in power-down
// - core clock is reference times multiplier when in range, else reference
package synth_pins_pkg;

	// ----------------------------------------------------------------
	// register bank shape
	// ----------------------------------------------------------------
	localparam int REG_W = 32;
	localparam int NUM_REGS = 8;
	localparam int ADDR_W = 3;

	// ----------------------------------------------------------------
	// serial framing: instruction byte then one data word, msb first
	// ----------------------------------------------------------------
	localparam int INSTR_W = 8;
	localparam int INSTR_RW_BIT = 7;
	localparam logic [5:0] BIT_CNT_ZERO = 6'h00;
	localparam logic [5:0] BIT_CNT_ONE = 6'h01;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int RESET_MIN_CYCLES = 5;
	localparam int SYNC_DIV = 4;
	localparam logic [1:0] SYNC_CNT_ZERO = 2'h0;
	localparam logic [1:0] SYNC_CNT_ONE = 2'h1;
	localparam logic [1:0] SYNC_CNT_HALF = 2'h2;

	// ----------------------------------------------------------------
	// reference multiplier range
	// ----------------------------------------------------------------
	localparam logic [4:0] MULT_MIN = 5'h04;
	localparam logic [4:0] MULT_MAX = 5'h14;
	localparam logic [4:0] MULT_UNITY = 5'h01;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic clk;
		logic sel_n;
		logic data;
	} serial_in_t;

	typedef struct packed {
		logic data;
		logic oe_n;
	} pin_drive_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INSTR = 2'b01,
		ST_DATA = 2'b10
	} port_state_t;

	localparam int SYNC_W = 16;
	localparam logic [SYNC_W-1:0] SYNC_RST = 16'h4000;

endpackage

// [write_buffer.sv]
`timescale 1ns/1ps
module write_buffer
	import synth_pins_pkg::*;
#(
	parameter int NUM = NUM_REGS,
	parameter int W = REG_W,
	parameter int AW = ADDR_W
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [W-1:0] wr_data_i,
	// every word at once, straight from the storage flops
	output logic [NUM-1:0][W-1:0] words_o
);

	// ----------------------------------------------------------------
	// storage, one word per entry
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM; g++) begin : g_word
			wire logic hit = wr_en_i && (wr_addr_i == AW'(g));
			always_ff @(posedge core_clk_i) begin
				if (reset_i) begin
					words_o[g] <= '0;
				end else if (hit) begin
					words_o[g] <= wr_data_i;
				end
			end
		end
	endgenerate

endmodule

// [synth_control_pin_interface_asserts.sv]
`timescale 1ns/1ps
module synth_control_pin_interface_asserts
	import synth_pins_pkg::*;
#(
	parameter int NUM = NUM_REGS,
	parameter int W = REG_W,
	parameter int AW = ADDR_W
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// serial port
	input wire serial_in_t serial_i,
	input wire logic serial_port_abort_i,
	input wire logic three_wire_mode_i,
	input wire pin_drive_t serial_data_o,
	input wire pin_drive_t serial_out_pin_o,
	// update and registers
	input wire logic io_update_i,
	input wire logic [NUM-1:0][W-1:0] active_regs_o,
	// sync and keying
	input wire logic sync_in_i,
	input wire logic sync_clk_o,
	input wire logic keying_enable_i,
	input wire logic keying_ramp_direction_i,
	input wire logic ramp_up_o,
	// clock and power control
	input wire logic oscillator_enable_pin_i,
	input wire logic external_powerdown_pin_i,
	input wire logic [4:0] refclk_mult_i,
	input wire logic osc_section_en_o,
	input wire logic ref_direct_o,
	input wire logic powerdown_o,
	input wire logic [4:0] pll_factor_o,
	input wire logic pll_bypass_o
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	// multiplier only counts inside its legal range
	wire mult_ok = (refclk_mult_i >= MULT_MIN) && (refclk_mult_i <= MULT_MAX);

	// one whole sync period after a rising edge
	sequence s_sync_rest;
		sync_clk_o ##1 !sync_clk_o ##1 !sync_clk_o ##1 sync_clk_o;
	endsequence
	// keying inputs left alone long enough to be sampled
	sequence s_key_still;
		($stable(keying_enable_i) && $stable(keying_ramp_direction_i))[*8];
	endsequence

	a_update_cause: assert property ($changed(active_regs_o) |-> $past(io_update_i, 3) || $past(io_update_i, 4) || $past(io_update_i, 5)) else $error("active registers moved without update");
	a_abort_quiet: assert property (serial_port_abort_i |-> serial_data_o.oe_n && serial_out_pin_o.oe_n) else $error("pin driven during abort");
	a_desel_quiet: assert property (serial_i.sel_n[*5] |-> serial_data_o.oe_n && serial_out_pin_o.oe_n) else $error("pin driven while deselected");
	a_three_wire: assert property (three_wire_mode_i[*4] |-> serial_data_o.oe_n) else $error("data pin driven in three-wire mode");
	a_two_wire: assert property ((!three_wire_mode_i)[*4] |-> serial_out_pin_o.oe_n) else $error("out pin driven in two-wire mode");
	a_sync_period: assert property (disable iff (reset_i || sync_in_i) $rose(sync_clk_o) |=> s_sync_rest) else $error("sync clock period wrong");
	a_ramp_dir: assert property (s_key_still |-> ##2 ramp_up_o == ($past(keying_enable_i, 2) && $past(keying_ramp_direction_i, 2))) else $error("ramp direction wrong");
	a_osc_follow: assert property ($stable(oscillator_enable_pin_i)[*5] |-> osc_section_en_o == oscillator_enable_pin_i && ref_direct_o == !oscillator_enable_pin_i) else $error("oscillator select wrong");
	a_pd_follow: assert property ($stable(external_powerdown_pin_i)[*5] |-> powerdown_o == external_powerdown_pin_i) else $error("power-down wrong");
	a_pll_map: assert property ($stable(refclk_mult_i)[*5] |-> pll_factor_o == (mult_ok ? refclk_mult_i : MULT_UNITY) && pll_bypass_o == !mult_ok) else $error("multiplier mapping wrong");
endmodule

bind synth_control_pin_interface synth_control_pin_interface_asserts #(.NUM(NUM), .W(W), .AW(AW)) u_asserts (.*);

// [host_port_model.sv]
`timescale 1ns/1ps
module host_port_model
	import synth_pins_pkg::*;
(
	// clock and mode
	input wire logic core_clk_i,
	input wire logic three_wire_mode_i,
	// device pins
	input wire pin_drive_t serial_data_i,
	input wire pin_drive_t serial_out_pin_i,
	output serial_in_t serial_o
);
	// ----------------------------------------------------------------
	// pin levels
	// ----------------------------------------------------------------
	logic sclk = 1'b0;
	logic sel_n = 1'b1;
	logic host_en = 1'b0;
	logic host_bit = 1'b0;
	logic idle_bit = 1'b0;
	logic line;
	logic so_line;

	// released line flips each cycle so a stale bit never looks valid
	always @(negedge core_clk_i) begin
		idle_bit <= ~idle_bit;
	end
	assign line = !serial_data_i.oe_n ? serial_data_i.data : (host_en ? host_bit : idle_bit);
	// the out pin counts only while the device enables it
	assign so_line = !serial_out_pin_i.oe_n ? serial_out_pin_i.data : idle_bit;
	assign serial_o = {sclk, sel_n, line};

	// one frame, msb first; a short frame leaves the select low
	task automatic xfer(input logic [7:0] instr, input logic [31:0] wdata, input int nbits,
		input logic sel, output logic [31:0] rdata);
		logic [39:0] frame;
		frame = {instr, wdata};
		rdata = 32'h0;
		@(negedge core_clk_i);
		sel_n = !sel;
		repeat (4) @(negedge core_clk_i);
		for (int i = 0; i < INSTR_W + nbits; i++) begin
			host_bit = frame[39 - i];
			host_en = !(instr[INSTR_RW_BIT] && i >= INSTR_W);
			repeat (5) @(negedge core_clk_i);
			if (i >= INSTR_W) begin
				rdata[39 - i] = three_wire_mode_i ? so_line : line;
			end
			sclk = 1'b1;
			repeat (3) @(negedge core_clk_i);
			sclk = 1'b0;
		end
		if (nbits == 32) begin
			repeat (4) @(negedge core_clk_i);
			sel_n = 1'b1;
			host_en = 1'b0;
		end
	endtask
endmodule

// [tb_synth_control_pin_interface.sv]
`timescale 1ns/1ps
module tb_synth_control_pin_interface;
	import synth_pins_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic core_clk_i = 1'b0, reset_i = 1'b1, serial_port_abort_i = 1'b0;
	logic three_wire_mode_i = 1'b0, io_update_i = 1'b0, sync_in_i = 1'b0;
	logic keying_enable_i = 1'b0, keying_ramp_direction_i = 1'b0;
	logic oscillator_enable_pin_i = 1'b1, external_powerdown_pin_i = 1'b0;
	logic [4:0] refclk_mult_i = 5'h08;
	serial_in_t serial_i;
	pin_drive_t serial_data_o, serial_out_pin_o;
	logic [NUM_REGS-1:0][REG_W-1:0] active_regs_o;
	logic sync_clk_o, ramp_up_o, osc_section_en_o, ref_direct_o, powerdown_o, pll_bypass_o;
	logic [4:0] pll_factor_o;
	logic [31:0] rd;
	int bad_count = 0;
	int comparisons = 0;

	// 100 MHz core clock
	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end

	synth_control_pin_interface dut (.*);
	host_port_model host (
		.core_clk_i(core_clk_i),
		.three_wire_mode_i(three_wire_mode_i),
		.serial_data_i(serial_data_o),
		.serial_out_pin_i(serial_out_pin_o),
		.serial_o(serial_i)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: expected %0h got %0h", $time, exp, got);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] v);
		host.xfer({5'h00, a}, v, 32, 1'b1, rd);
	endtask
	task automatic upd();
		io_update_i = 1'b1;
		wait_n(2);
		io_update_i = 1'b0;
		wait_n(8);
	endtask
	task automatic pulse_abort();
		serial_port_abort_i = 1'b1;
		wait_n(3);
		serial_port_abort_i = 1'b0;
		wait_n(4);
	endtask
	task automatic print_verdict();
		$display("counts: %0d compares, %0d mismatches", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check(32'h0, active_regs_o[2]);
		check(32'h0287, {19'h0, sync_clk_o, ramp_up_o, osc_section_en_o, ref_direct_o,
			powerdown_o, pll_bypass_o, pll_factor_o, serial_data_o.oe_n, serial_out_pin_o.oe_n});
		reset_i = 1'b0;
		wait_n(6);
		$display("reset test done");
	endtask
	task automatic t_write_update();
		wr(3'h3, 32'hA5C3_0F01);
		wr(3'h0, 32'h1234_5678);
		wait_n(10);
		check(32'h0, active_regs_o[3]);
		upd();
		check(32'hA5C3_0F01, active_regs_o[3]);
		check(32'h1234_5678, active_regs_o[0]);
		$display("write and update test done");
	endtask
	task automatic t_read();
		three_wire_mode_i = 1'b1;
		wait_n(4);
		host.xfer(8'h83, 32'h0, 32, 1'b1, rd);
		check(32'hA5C3_0F01, rd);
		three_wire_mode_i = 1'b0;
		wait_n(4);
		host.xfer(8'h80, 32'h0, 32, 1'b1, rd);
		check(32'h1234_5678, rd);
		$display("read test done");
	endtask
	task automatic t_abort();
		host.xfer(8'h83, 32'h0, 8, 1'b1, rd);
		check(32'h0, 32'(serial_data_o.oe_n));
		serial_port_abort_i = 1'b1;
		#1;
		check(32'h1, 32'(serial_data_o.oe_n));
		wait_n(3);
		serial_port_abort_i = 1'b0;
		wait_n(4);
		host.xfer(8'h05, 32'hDEAD_BEEF, 16, 1'b1, rd);
		pulse_abort();
		wr(3'h5, 32'h0BAD_CAFE);
		upd();
		check(32'h0BAD_CAFE, active_regs_o[5]);
		$display("abort test done");
	endtask
	task automatic t_select();
		host.xfer(8'h06, 32'hFFFF_FFFF, 32, 1'b0, rd);
		upd();
		check(32'h0, active_regs_o[6]);
		reset_i = 1'b1;
		wait_n(RESET_MIN_CYCLES);
		check(32'h0, active_regs_o[0]);
		reset_i = 1'b0;
		wait_n(6);
		$display("select and reset test done");
	endtask
	task automatic t_pins();
		logic [4:0] m [6] = '{5'h00, 5'h03, 5'h04, 5'h0C, 5'h14, 5'h15};
		logic ok;
		for (int i = 0; i < 6; i++) begin
			refclk_mult_i = m[i];
			oscillator_enable_pin_i = i[0];
			external_powerdown_pin_i = i[1];
			wait_n(8);
			ok = (m[i] >= MULT_MIN) && (m[i] <= MULT_MAX);
			check({26'h0, ok ? m[i] : MULT_UNITY, !ok}, {26'h0, pll_factor_o, pll_bypass_o});
			check({29'h0, i[0], !i[0], i[1]}, {29'h0, osc_section_en_o, ref_direct_o, powerdown_o});
		end
		// keying moves only just after a sync clock edge
		for (int j = 0; j < 4; j++) begin
			@(posedge sync_clk_o);
			wait_n(1);
			keying_enable_i = j[1];
			keying_ramp_direction_i = j[0];
			wait_n(12);
			check({31'h0, j == 3}, {31'h0, ramp_up_o});
		end
		keying_enable_i = 1'b0;
		keying_ramp_direction_i = 1'b0;
		$display("pin control test done");
	endtask
	task automatic wait_rise(output int n);
		logic prev;
		n = 0;
		do begin
			prev = sync_clk_o;
			wait_n(1);
			n++;
		end while ((prev || !sync_clk_o) && n < 50);
	endtask
	task automatic t_sync();
		int d [2];
		int n;
		// two peer edges one cycle apart must land on the same local phase
		for (int k = 0; k < 2; k++) begin
			@(posedge sync_clk_o);
			wait_n(k + 1);
			sync_in_i = 1'b1;
			wait_n(6);
			wait_rise(n);
			d[k] = n;
			sync_in_i = 1'b0;
			wait_rise(n);
			wait_rise(n);
			check(32'(SYNC_DIV), 32'(n));
		end
		check(32'(d[0]), 32'(d[1]));
		$display("sync test done");
	endtask

	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(negedge core_clk_i);
		t_reset();
		t_write_update();
		t_read();
		t_abort();
		t_select();
		t_pins();
		t_sync();
		print_verdict();
	end
	// generous: whole run is a few thousand cycles
	initial begin
		#500000;
		bad_count++;
		$display("watchdog expired");
		print_verdict();
	end
endmodule
